// file: rtl/dual_timer_pkg.sv
package dual_timer_pkg;

    // ==========================================
    // Operating modes
    // ==========================================
    typedef enum logic [1:0]
    {
        MODE_PRESCALED = 2'b00,  // 13-bit prescaled
        MODE_CASCADE   = 2'b01,  // 16-bit cascade
        MODE_RELOAD    = 2'b10,  // 8-bit auto-reload
        MODE_SPLIT     = 2'b11   // Split (A) or halt (B)
    } timer_mode_t;

    // Per-unit mode settings, one nibble of the mode register
    typedef struct packed
    {
        logic        gate_bit;   // Gate pin enables counting
        logic        source_bit; // 1: external pin, 0: peripheral cycle
        timer_mode_t mode;       // Mode select
    } unit_cfg_t;

    // Count bytes of a unit
    typedef struct packed
    {
        logic [7:0] high_byte;   // Count high byte
        logic [7:0] low_byte;    // Count low byte
    } unit_count_t;

    // ==========================================
    // Positions and timing
    // ==========================================
    localparam int          PER_CYCLE_CLKS     = 6;   // Peripheral clocks per cycle
    localparam int          EDGE_CYCLES        = 2;   // Cycles to see an edge
    localparam int          PRESCALE_BITS      = 5;   // Modulo-32 prescaler
    localparam int          UNIT_A_MODE_LSB    = 0;   // Unit A nibble in mode register
    localparam int          UNIT_B_MODE_LSB    = 4;   // Unit B nibble in mode register
    localparam int          CTRL_A_RUN_POS     = 4;   // Unit A run bit
    localparam int          CTRL_A_FLAG_POS    = 5;   // Unit A overflow flag
    localparam int          CTRL_B_RUN_POS     = 6;   // Unit B run bit
    localparam int          CTRL_B_FLAG_POS    = 7;   // Unit B overflow flag
    localparam logic [7:0]  COUNT_RESET        = 8'h00; // Count byte reset value
    localparam logic [7:0]  MODE_REG_RESET     = 8'h00; // Mode register reset value
    localparam logic [2:0]  DIV_LAST           = 3'h5;  // Divider terminal count

endpackage : dual_timer_pkg

// file: rtl/timer_unit.sv
`timescale 1ns/1ps

// ==========================================
// One counter unit: low byte, high byte, modes 0..2 and split low byte
// ==========================================
module timer_unit
(
    input  wire logic                    CLK,        // Peripheral clock
    input  wire logic                    RSTN,       // Synchronous reset, active low
    input  wire logic                    cnt_en,     // Count this cycle
    input  wire dual_timer_pkg::unit_cfg_t cfg,      // Mode settings
    input  wire logic                    halt,       // Hold count (B in mode 3)
    input  wire logic                    wr_high,    // Software writes high byte
    input  wire logic                    wr_low,     // Software writes low byte
    input  wire logic [7:0]              wr_data,    // Write data
    input  wire logic                    high_run,   // Split high byte runs
    output dual_timer_pkg::unit_count_t  count,      // Count bytes
    output logic                         low_ovf,    // Main overflow pulse
    output logic                         high_ovf    // Split high overflow pulse
);

    logic [7:0] high_reg;                 // High byte
    logic [7:0] low_reg;                  // Low byte
    logic [7:0] high_next;                // Next high byte
    logic [7:0] low_next;                 // Next low byte
    logic       ovf_next;                 // Main overflow this cycle
    logic       hovf_next;                // Split high overflow this cycle

    // ==========================================
    // Count logic per mode
    // ==========================================
    always_comb
    begin
        high_next = high_reg;
        low_next  = low_reg;
        ovf_next  = 1'b0;
        hovf_next = 1'b0;
        if (cnt_en && !halt)
        begin
            unique case (cfg.mode)
                dual_timer_pkg::MODE_PRESCALED:
                begin
                    // Upper three low bits left as they are
                    low_next[4:0] = low_reg[4:0] + 5'h01;
                    if (low_reg[4:0] == 5'h1f)
                    begin
                        high_next = high_reg + 8'h01;
                        ovf_next  = (high_reg == 8'hff);
                    end
                end
                dual_timer_pkg::MODE_CASCADE:
                begin
                    low_next = low_reg + 8'h01;
                    if (low_reg == 8'hff)
                    begin
                        high_next = high_reg + 8'h01;
                        ovf_next  = (high_reg == 8'hff);
                    end
                end
                dual_timer_pkg::MODE_RELOAD:
                begin
                    // Reload uses whatever high byte holds now
                    if (low_reg == 8'hff)
                    begin
                        low_next = high_reg;
                        ovf_next = 1'b1;
                    end
                    else
                        low_next = low_reg + 8'h01;
                end
                dual_timer_pkg::MODE_SPLIT:
                begin
                    low_next = low_reg + 8'h01;
                    ovf_next = (low_reg == 8'hff);
                end
            endcase
        end
        // Split high byte counts every peripheral cycle on its own run bit
        if (high_run && !halt)
        begin
            high_next = high_reg + 8'h01;
            hovf_next = (high_reg == 8'hff);
        end
        // Software writes win; legal only while stopped, except reload value
        if (wr_high)
            high_next = wr_data;
        if (wr_low)
            low_next = wr_data;
    end

    // ==========================================
    // Count registers; run start keeps contents
    // ==========================================
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            high_reg <= dual_timer_pkg::COUNT_RESET;
            low_reg  <= dual_timer_pkg::COUNT_RESET;
            low_ovf  <= 1'b0;
            high_ovf <= 1'b0;
        end
        else
        begin
            high_reg <= high_next;
            low_reg  <= low_next;
            low_ovf  <= ovf_next;
            high_ovf <= hovf_next;
        end
    end

    assign count = '{high_byte: high_reg, low_byte: low_reg};

endmodule : timer_unit

// file: rtl/dual_timer_event_counter.sv
`timescale 1ns/1ps


module dual_timer_event_counter
(
    input  wire logic       CLK,            // 40 MHz peripheral clock
    input  wire logic       RSTN,           // Synchronous reset, active low
    input  wire logic [7:0] MODE_WR_DATA,   // Mode register write data
    input  wire logic       MODE_WR,        // Mode register write strobe
    input  wire logic       A_RUN_BIT,      // Unit A run bit
    input  wire logic       B_RUN_BIT,      // Unit B run bit
    input  wire logic       A_FLAG_CLR,     // Unit A interrupt serviced
    input  wire logic       B_FLAG_CLR,     // Unit B interrupt serviced
    input  wire logic       A_HIGH_WR,      // Write unit A high byte
    input  wire logic       A_LOW_WR,       // Write unit A low byte
    input  wire logic       B_HIGH_WR,      // Write unit B high byte
    input  wire logic       B_LOW_WR,       // Write unit B low byte
    input  wire logic [7:0] BYTE_WR_DATA,   // Count byte write data
    input  wire logic       A_COUNT_PIN,    // Unit A external count pin
    input  wire logic       B_COUNT_PIN,    // Unit B external count pin
    input  wire logic       A_GATE_PIN,     // Unit A gate pin
    input  wire logic       B_GATE_PIN,     // Unit B gate pin
    output logic [7:0]      MODE_REG,       // Mode register readback
    output logic [15:0]     A_COUNT,        // Unit A high and low bytes
    output logic [15:0]     B_COUNT,        // Unit B high and low bytes
    output logic            A_OVF_FLAG,     // Unit A overflow flag / request
    output logic            B_OVF_FLAG      // Unit B overflow flag / request
);

    // ==========================================
    // Declarations
    // ==========================================
    logic [7:0]                mode_reg;          // Mode register
    logic [2:0]                div_reg;           // Six-clock divider
    logic                      per_tick;          // Peripheral cycle enable
    logic [2:0]                cpin_a_sync;       // Count pin A synchroniser
    logic [2:0]                cpin_b_sync;       // Count pin B synchroniser
    logic [2:0]                gpin_a_sync;       // Gate pin A synchroniser
    logic [2:0]                gpin_b_sync;       // Gate pin B synchroniser
    logic                      cpin_a_lvl;        // Filtered count pin A level
    logic                      cpin_b_lvl;        // Filtered count pin B level
    logic                      gpin_a_lvl;        // Filtered gate pin A level
    logic                      gpin_b_lvl;        // Filtered gate pin B level
    logic                      samp_a_reg;        // Count pin A sample, last cycle
    logic                      samp_b_reg;        // Count pin B sample, last cycle
    logic                      prev_a_reg;        // Count pin A sample, cycle before
    logic                      prev_b_reg;        // Count pin B sample, cycle before
    logic                      gate_a_reg;        // Sampled gate A
    logic                      gate_b_reg;        // Sampled gate B
    logic                      fall_a;            // Falling edge seen on A
    logic                      fall_b;            // Falling edge seen on B
    dual_timer_pkg::unit_cfg_t cfg_a;             // Unit A settings
    dual_timer_pkg::unit_cfg_t cfg_b;             // Unit B settings
    logic                      enable_a;          // Unit A may count
    logic                      enable_b;          // Unit B may count
    logic                      inc_a;             // Unit A count pulse
    logic                      inc_b;             // Unit B count pulse
    logic                      split_a;           // Unit A in mode 3
    logic                      halt_b;            // Unit B in mode 3
    dual_timer_pkg::unit_count_t cnt_a;           // Unit A bytes
    dual_timer_pkg::unit_count_t cnt_b;           // Unit B bytes
    logic                      ovf_a;             // Unit A overflow pulse
    logic                      ovf_b;             // Unit B overflow pulse
    logic                      hovf_a;            // Split high byte overflow
    logic                      flag_a_reg;        // Unit A overflow flag
    logic                      flag_b_reg;        // Unit B overflow flag

    // ==========================================
    // Mode register
    // ==========================================
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            mode_reg <= dual_timer_pkg::MODE_REG_RESET;
        else if (MODE_WR)
            mode_reg <= MODE_WR_DATA;
    end

    // Nibble split per unit
    assign cfg_a = dual_timer_pkg::unit_cfg_t'(mode_reg[dual_timer_pkg::UNIT_A_MODE_LSB +: 4]);
    assign cfg_b = dual_timer_pkg::unit_cfg_t'(mode_reg[dual_timer_pkg::UNIT_B_MODE_LSB +: 4]);
    assign split_a = (cfg_a.mode == dual_timer_pkg::MODE_SPLIT);
    assign halt_b  = (cfg_b.mode == dual_timer_pkg::MODE_SPLIT);

    // ==========================================
    // Peripheral cycle divider
    // ==========================================
    // Divide by six; tick on the last clock of each cycle
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            div_reg <= 3'h0;
        else if (div_reg == dual_timer_pkg::DIV_LAST)
            div_reg <= 3'h0;
        else
            div_reg <= div_reg + 3'h1;
    end

    assign per_tick = (div_reg == dual_timer_pkg::DIV_LAST);

    // ==========================================
    // Pin synchronisers
    // ==========================================
    // Three stages; only stage two and three feed the filter
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            cpin_a_sync <= 3'h0;
            cpin_b_sync <= 3'h0;
            gpin_a_sync <= 3'h0;
            gpin_b_sync <= 3'h0;
        end
        else
        begin
            cpin_a_sync <= {cpin_a_sync[1:0], A_COUNT_PIN};
            cpin_b_sync <= {cpin_b_sync[1:0], B_COUNT_PIN};
            gpin_a_sync <= {gpin_a_sync[1:0], A_GATE_PIN};
            gpin_b_sync <= {gpin_b_sync[1:0], B_GATE_PIN};
        end
    end

    // Filtered levels change only when stages two and three agree
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            cpin_a_lvl <= 1'b0;
            cpin_b_lvl <= 1'b0;
            gpin_a_lvl <= 1'b0;
            gpin_b_lvl <= 1'b0;
        end
        else
        begin
            if (cpin_a_sync[1] == cpin_a_sync[2])
                cpin_a_lvl <= cpin_a_sync[2];
            if (cpin_b_sync[1] == cpin_b_sync[2])
                cpin_b_lvl <= cpin_b_sync[2];
            if (gpin_a_sync[1] == gpin_a_sync[2])
                gpin_a_lvl <= gpin_a_sync[2];
            if (gpin_b_sync[1] == gpin_b_sync[2])
                gpin_b_lvl <= gpin_b_sync[2];
        end
    end

    // ==========================================
    // Per-cycle sampling of count and gate pins
    // ==========================================
    // One sample per peripheral cycle; a pulse shorter than a cycle may be
    // missed, which is why the source must hold each level that long
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            samp_a_reg <= 1'b0;
            samp_b_reg <= 1'b0;
            prev_a_reg <= 1'b0;
            prev_b_reg <= 1'b0;
            gate_a_reg <= 1'b0;
            gate_b_reg <= 1'b0;
        end
        else if (per_tick)
        begin
            samp_a_reg <= cpin_a_lvl;
            samp_b_reg <= cpin_b_lvl;
            prev_a_reg <= samp_a_reg;
            prev_b_reg <= samp_b_reg;
            gate_a_reg <= gpin_a_lvl;
            gate_b_reg <= gpin_b_lvl;
        end
    end

    // High in one sample, low in the next; spans two cycles
    assign fall_a = prev_a_reg && !samp_a_reg;
    assign fall_b = prev_b_reg && !samp_b_reg;

    // ==========================================
    // Count enables
    // ==========================================
    assign enable_a = A_RUN_BIT && (!cfg_a.gate_bit || gate_a_reg);
    // With A split its high byte owns B's run bit, so B runs whenever out of mode 3 and its gate allows
    assign enable_b = (split_a || B_RUN_BIT) && (!cfg_b.gate_bit || gate_b_reg);

    // At most one step per peripheral cycle, from either source
    assign inc_a = per_tick && enable_a && (cfg_a.source_bit ? fall_a : 1'b1);
    assign inc_b = per_tick && enable_b && (cfg_b.source_bit ? fall_b : 1'b1);

    // ==========================================
    // Units
    // ==========================================
    timer_unit unit_a
    (
        .CLK      (CLK),
        .RSTN     (RSTN),
        .cnt_en   (inc_a),
        .cfg      (cfg_a),
        .halt     (1'b0),
        .wr_high  (A_HIGH_WR),
        .wr_low   (A_LOW_WR),
        .wr_data  (BYTE_WR_DATA),
        .high_run (split_a && B_RUN_BIT && per_tick),
        .count    (cnt_a),
        .low_ovf  (ovf_a),
        .high_ovf (hovf_a)
    );

    // Unit B keeps counting with A split, but its flag is taken over
    timer_unit unit_b
    (
        .CLK      (CLK),
        .RSTN     (RSTN),
        .cnt_en   (inc_b),
        .cfg      (cfg_b),
        .halt     (halt_b),
        .wr_high  (B_HIGH_WR),
        .wr_low   (B_LOW_WR),
        .wr_data  (BYTE_WR_DATA),
        .high_run (1'b0),
        .count    (cnt_b),
        .low_ovf  (ovf_b),
        .high_ovf ()
    );

    // ==========================================
    // Overflow flags; set wins over service clear
    // ==========================================
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            flag_a_reg <= 1'b0;
            flag_b_reg <= 1'b0;
        end
        else
        begin
            if (ovf_a)
                flag_a_reg <= 1'b1;
            else if (A_FLAG_CLR)
                flag_a_reg <= 1'b0;
            // With A split, only A's high byte reaches B's flag
            if (split_a ? hovf_a : ovf_b)
                flag_b_reg <= 1'b1;
            else if (B_FLAG_CLR)
                flag_b_reg <= 1'b0;
        end
    end

    assign MODE_REG   = mode_reg;
    assign A_COUNT    = cnt_a;
    assign B_COUNT    = cnt_b;
    assign A_OVF_FLAG = flag_a_reg;
    assign B_OVF_FLAG = flag_b_reg;

    // ==========================================
    // Assertions
    // ==========================================
    tick_spacing_a: assert property (@(posedge CLK) disable iff (!RSTN)
        per_tick |=> !per_tick [*5] ##1 per_tick)
        else $error("Peripheral tick not every six clocks");

    flag_set_a: assert property (@(posedge CLK) disable iff (!RSTN)
        ovf_a |=> A_OVF_FLAG)
        else $error("Unit A overflow did not set flag");

    flag_clear_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (A_FLAG_CLR && !ovf_a) |=> !A_OVF_FLAG)
        else $error("Unit A flag not cleared on service");

    halt_hold_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (halt_b && !B_HIGH_WR && !B_LOW_WR && $past(halt_b)) |=> $stable(B_COUNT))
        else $error("Unit B count moved while halted");

    run_gate_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (!A_RUN_BIT || (cfg_a.gate_bit && !gate_a_reg)) |-> !inc_a)
        else $error("Unit A counted while disabled");

    reload_value_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (inc_a && cfg_a.mode == dual_timer_pkg::MODE_RELOAD && cnt_a.low_byte == 8'hff
         && !A_LOW_WR && !A_HIGH_WR) |=> (A_COUNT[7:0] == $past(A_COUNT[15:8])))
        else $error("Unit A did not reload from high byte");

    edge_rate_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (inc_a && cfg_a.source_bit) |=> !inc_a [*8])
        else $error("Unit A counted edges too fast");

    cascade_carry_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (inc_a && cfg_a.mode == dual_timer_pkg::MODE_CASCADE && cnt_a == 16'hffff
         && !A_LOW_WR && !A_HIGH_WR) |=> (A_COUNT == 16'h0000) ##1 A_OVF_FLAG)
        else $error("Unit A cascade overflow wrong");

    split_flag_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (split_a && ovf_b && !hovf_a && !$past(B_OVF_FLAG) && !B_OVF_FLAG) |=> !B_OVF_FLAG)
        else $error("Unit B overflow set flag while A split");

    cov_cascade_c: cover property (@(posedge CLK) ovf_a && cfg_a.mode == dual_timer_pkg::MODE_CASCADE);
    cov_reload_c:  cover property (@(posedge CLK) ovf_b && cfg_b.mode == dual_timer_pkg::MODE_RELOAD);
    cov_edge_c:    cover property (@(posedge CLK) inc_a && cfg_a.source_bit);
    cov_split_c:   cover property (@(posedge CLK) hovf_a && split_a);

endmodule : dual_timer_event_counter

// file: tb/ext_pin_model.sv
`timescale 1ns/1ps

// ==========================================
// External count source: falling edges on demand
// ==========================================
module ext_pin_model
(
    input  wire logic       CLK,   // Peripheral clock
    input  wire logic [7:0] EDGES, // Falling edges per burst
    input  wire logic       START, // Rising edge starts a burst
    output logic            PIN    // Count pin, idles high
);
    initial PIN = 1'b1;
    // Each level held 12 clocks, two full peripheral cycles, for margin
    always @(posedge START)
    begin
        repeat (EDGES)
        begin
            repeat (12) @(negedge CLK);
            PIN = 1'b0;
            repeat (12) @(negedge CLK);
            PIN = 1'b1;
        end
    end
endmodule : ext_pin_model

// file: tb/dual_timer_event_counter_tb_top.sv
`timescale 1ns/1ps

module dual_timer_event_counter_tb_top;
    logic       clk = 0, rstn = 0, mwr = 0, arun = 0, brun = 0, aclr = 0, bclr = 0;
    logic       ahw = 0, alw = 0, bhw = 0, blw = 0, agate = 0, bgate = 1, go = 0, apin;
    logic [7:0] mdat = 8'h00, bdat = 8'h00, nedg = 8'h00, mreg, h;
    logic [15:0] acnt, bcnt, c0, c1;
    logic       aflag, bflag;
    int         failures = 0, checks = 0, cyc = 0, i;
    // ==========================================
    // Clock, timeout, design and pin source
    // ==========================================
    always #12.5 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            report_and_stop();
        end
    end
    dual_timer_event_counter u_dual_timer_event_counter (.CLK(clk), .RSTN(rstn),
        .MODE_WR_DATA(mdat), .MODE_WR(mwr), .A_RUN_BIT(arun), .B_RUN_BIT(brun),
        .A_FLAG_CLR(aclr), .B_FLAG_CLR(bclr), .A_HIGH_WR(ahw), .A_LOW_WR(alw),
        .B_HIGH_WR(bhw), .B_LOW_WR(blw), .BYTE_WR_DATA(bdat), .A_COUNT_PIN(apin),
        .B_COUNT_PIN(apin), .A_GATE_PIN(agate), .B_GATE_PIN(bgate), .MODE_REG(mreg),
        .A_COUNT(acnt), .B_COUNT(bcnt), .A_OVF_FLAG(aflag), .B_OVF_FLAG(bflag));
    ext_pin_model u_ext_pin_model (.CLK(clk), .EDGES(nedg), .START(go), .PIN(apin));
    // ==========================================
    // Helpers: inputs move on falling edges only
    // ==========================================
    task automatic wc(input int n);
        repeat (n) @(negedge clk);
    endtask : wc
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic mode(input logic [7:0] d);
        {mwr, mdat} = {1'b1, d};
        wc(1);
        mwr = 1'b0;
        // Let an edge pass so back-to-back calls never rewrite a strobe at once
        wc(1);
    endtask : mode
    // Byte writes only while stopped, except the reload byte
    task automatic wb(input int sel, input logic [7:0] d);
        bdat = d;
        {ahw, alw, bhw, blw} = 4'b1000 >> sel;
        wc(1);
        {ahw, alw, bhw, blw} = 4'b0000;
        wc(1);
    endtask : wb
    // Mode 0 reference: five-bit prescaler carries into the high byte
    function automatic logic [15:0] pre_step(input logic [15:0] v, input int n);
        repeat (n)
        begin
            v[4:0] = v[4:0] + 5'h01;
            if (v[4:0] == 5'h00)
                v[15:8] = v[15:8] + 8'h01;
        end
        return v;
    endfunction : pre_step
    // Poll one overflow flag, bounded so a dead counter cannot hang
    task automatic wait_flag(input logic sel);
        c0 = 16'h0000;
        while ((sel ? bflag : aflag) !== 1'b1 && c0 < 16'h0200)
        begin
            wc(1);
            c0++;
        end
    endtask : wait_flag
    task automatic report_and_stop();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    // ==========================================
    // Main sequence
    // ==========================================
    initial
    begin
        void'($urandom(32'h2f2dfb47));
        wc(6);
        rstn = 1'b1;
        wc(1);
        chk(acnt | bcnt, 16'h0000);
        chk({aflag, bflag, mreg}, 16'h0000);
        // Cascade wrap from a preset kept by the run bit
        mode(8'h11);
        wb(1, 8'hfe);
        wb(0, 8'hff);
        arun = 1'b1;
        wc(14);
        chk(aflag, 1'b1);
        c0 = acnt;
        wc(60);
        chk(acnt, c0 + 16'h000a);
        arun = 1'b0;
        aclr = 1'b1;
        wc(1);
        aclr = 1'b0;
        wc(1);
        chk(aflag, 1'b0);
        $display("test cascade done");
        // Auto-reload on B, second reload byte written while running
        mode(8'h21);
        for (i = 0; i < 2; i++)
        begin
            h = 8'(8'hc8 + $urandom_range(0, 50));
            brun = (i == 1);
            wb(2, h);
            if (i == 0)
                wb(3, 8'hff);
            brun = 1'b1;
            wait_flag(1'b1);
            brun = 1'b0;
            bclr = 1'b1;
            wc(1);
            bclr = 1'b0;
            chk(bcnt, {h, h});
        end
        $display("test reload done");
        // External falling edges
        mode(8'h55);
        for (i = 0; i < 4; i++)
            wb(i, 8'h00);
        nedg = 8'($urandom_range(3, 9));
        {arun, brun, go} = 3'b111;
        wc(24 * nedg + 40);
        chk(acnt, {8'h00, nedg});
        chk(bcnt, {8'h00, nedg});
        {arun, brun} = 2'b00;
        $display("test edges done");
        // Gate pin low holds, high lets the timer run
        mode(8'h99);
        {arun, brun} = 2'b11;
        {c0, c1} = {acnt, bcnt};
        wc(60);
        chk(acnt, c0);
        chk(bcnt, c1 + 16'h000a);
        {agate, bgate} = 2'b10;
        wc(20);
        {c0, c1} = {acnt, bcnt};
        wc(60);
        chk(acnt, c0 + 16'h000a);
        chk(bcnt, c1);
        {arun, brun} = 2'b00;
        $display("test gate done");
        // B halted by mode 3
        mode(8'h31);
        chk(mreg, 8'h31);
        brun = 1'b1;
        c0 = bcnt;
        wc(60);
        chk(bcnt, c0);
        brun = 1'b0;
        $display("test halt done");
        // Mode 0: prescaler wrap carries into a full high byte
        mode(8'h30);
        wb(0, 8'hff);
        wb(1, 8'hbc);
        arun = 1'b1;
        wait_flag(1'b0);
        arun = 1'b0;
        chk(acnt, pre_step(16'hffbc, 4));
        chk(aflag, 1'b1);
        aclr = 1'b1;
        wc(1);
        aclr = 1'b0;
        $display("test prescale done");
        // Mode 3 on A: low byte on A controls, high byte on B's run bit and flag
        mode(8'h33);
        wb(0, 8'hfe);
        wb(1, 8'hfd);
        {arun, brun} = 2'b11;
        wait_flag(1'b0);
        {arun, brun} = 2'b00;
        chk(acnt, 16'h0100);
        chk({aflag, bflag}, 2'b11);
        {aclr, bclr} = 2'b11;
        wc(1);
        {aclr, bclr} = 2'b00;
        // B let out of mode 3 runs five ticks, its overflow raising no flag
        wb(3, 8'hfe);
        wb(2, 8'h40);
        mode(8'h23);
        wc(28);
        mode(8'h33);
        chk(bcnt, 16'h4043);
        chk({aflag, bflag}, 2'b00);
        $display("test split done");
        report_and_stop();
    end
endmodule : dual_timer_event_counter_tb_top
